// [design/wdcc_core.sv]
// Contract
// [RQ1] Counter held clear when mode is off, or software mode with enable low.
// [RQ2] Awake-only mode: sleep entry clears counter and keeps it stopped in sleep.
// [RQ3] Wake with non-crystal clock clears counter once, then counting resumes.
// [RQ4] Wake with crystal clock holds counter clear until start-up timer done.
// [RQ5] Internal oscillator divider change leaves counter untouched.
// [RQ6] Clear instruction zeroes the counter, restarting the full interval.
// [RQ7] Mode 11 always on, 10 awake only, 01 software enable, 00 off.
// [RQ8] Time-out in sleep wakes device, no reset, and updates status flags.
// [RQ9] Oscillator-failure indication clears the counter.
//
// Purpose: Watchdog counter with its clear, hold and time-out control
// Assumes: lfTick is a one-cycle enable at the low-frequency oscillator rate
// Notes:   Sleep entry always clears; counting in sleep only in always-on or
//          enabled software mode
`timescale 1ns/1ps
`default_nettype none
module wdcc_core
    import wdcc_pkg::*;
#(
    parameter int unsigned       CNT_W = WDCC_CNT_W_DEF,
    parameter logic [CNT_W-1:0]  TERM  = WDCC_TERM_DEF[CNT_W-1:0]
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             lfTick,
    input  wire wdcc_cfg_s        cfg,
    input  wire logic             sleepEnter,
    input  wire logic             sleepExit,
    input  wire logic             oscFail,
    input  wire logic             watchdogClearInstr,
    input  wire logic             oscStartupTimerDone,
    input  wire logic [3:0]       internalOscDividerSel,
    input  wire logic             flagClear,
    output logic [CNT_W-1:0]      watchdogCounter,
    output logic                  watchdogActive,
    output logic                  timeoutReset,
    output logic                  timeoutWake,
    output wdcc_flags_s           flags
);

    // ----------------------------------------
    // Mode decode
    // ----------------------------------------
    // Flag values for idle and for a sleep-time time-out
    localparam wdcc_flags_s FLAGS_IDLE = '{timeoutFlag:   WDCC_FLAG_RST,
                                           powerdownFlag: WDCC_FLAG_RST};
    localparam wdcc_flags_s FLAGS_WAKE = '{timeoutFlag:   1'b0,
                                           powerdownFlag: 1'b0};

    wdcc_state_e state;
    wdcc_state_e next_state;

    wire logic modeOff;
    wire logic modeSw;
    wire logic modeAwakeOnly;
    wire logic modeAlways;
    wire logic swOn;
    wire logic awakeEnable;
    wire logic sleepEnable;

    assign modeOff       = (cfg.watchdogModeCfg == WDCC_MODE_OFF);               // RQ7
    assign modeSw        = (cfg.watchdogModeCfg == WDCC_MODE_SW);                // RQ7
    assign modeAwakeOnly = (cfg.watchdogModeCfg == WDCC_MODE_AWAKE);             // RQ7
    assign modeAlways    = (cfg.watchdogModeCfg == WDCC_MODE_ALWAYS);            // RQ7
    assign swOn          = modeSw && cfg.softwareWatchdogEnable && !modeOff;     // RQ7
    // Software mode behaves the same awake and asleep
    assign awakeEnable   = modeAlways || modeAwakeOnly || swOn;                  // RQ1 RQ7
    assign sleepEnable   = modeAlways || swOn;                                   // RQ2 RQ7

    // ----------------------------------------
    // Device phase
    // ----------------------------------------
    wire logic inAwake;
    wire logic inSleep;
    wire logic inStartupHold;
    wire logic enabledNow;
    wire logic crystalClk;

    assign inAwake       = (state == WDCC_ST_AWAKE);
    assign inSleep       = (state == WDCC_ST_SLEEP);
    assign inStartupHold = (state == WDCC_ST_OSTWAIT);
    // The start-up hold counts as awake; its own clear term keeps the counter at zero
    assign enabledNow    = inSleep ? sleepEnable : awakeEnable;
    assign crystalClk    = (cfg.sysClkSel == WDCC_CLK_XTAL_LP)
                           || (cfg.sysClkSel == WDCC_CLK_XTAL_MED)
                           || (cfg.sysClkSel == WDCC_CLK_XTAL_HS);               // RQ4

    // ----------------------------------------
    // Divider selection
    // ----------------------------------------
    // Divider changes reach no clear or count term, so the counter runs on
    wire logic dividerUnused;

    assign dividerUnused = ^internalOscDividerSel;                               // RQ5

    // ----------------------------------------
    // Count enable and terminal count
    // ----------------------------------------
    wire logic countTick;
    wire logic atTerm;
    wire logic wakeByTimeout;
    wire logic awakeTimeout;

    assign countTick     = enabledNow && lfTick;
    assign atTerm        = countTick && (watchdogCounter == TERM);
    // A time-out in sleep wakes the device instead of resetting it
    assign wakeByTimeout = inSleep && atTerm;                                    // RQ8
    assign awakeTimeout  = atTerm && !inSleep;                                   // RQ8

    // ----------------------------------------
    // Sleep entry and exit
    // ----------------------------------------
    wire logic takeSleep;
    wire logic takeWake;

    // Sleep requests count only while awake, wake requests only while asleep
    assign takeSleep     = inAwake && sleepEnter;
    assign takeWake      = inSleep && (sleepExit || wakeByTimeout);

    // ----------------------------------------
    // Sleep and start-up sequencing
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            WDCC_ST_AWAKE: begin
                if (takeSleep) begin
                    next_state = WDCC_ST_SLEEP;
                end
            end
            WDCC_ST_SLEEP: begin
                if (takeWake) begin
                    next_state = crystalClk ? WDCC_ST_OSTWAIT : WDCC_ST_AWAKE; // RQ3 RQ4
                end
            end
            WDCC_ST_OSTWAIT: begin
                if (oscStartupTimerDone) begin
                    next_state = WDCC_ST_AWAKE;
                end
            end
            default: begin
                next_state = WDCC_ST_AWAKE;
            end
        endcase
    end

    // ----------------------------------------
    // Clear sources, each one a named term
    // ----------------------------------------
    wire logic clrDisabled;
    wire logic clrSleepEntry;
    wire logic clrSleepHeld;
    wire logic clrWake;
    wire logic clrStartup;
    wire logic clrInstr;
    wire logic clrOscFail;
    wire logic clrWrap;
    wire logic clearNow;

    assign clrDisabled   = !awakeEnable && !inSleep;                             // RQ1
    assign clrSleepEntry = takeSleep;                                            // RQ2
    assign clrSleepHeld  = inSleep && !sleepEnable;                              // RQ2
    assign clrWake       = takeWake;                                             // RQ3
    // Held for the whole start-up wait, not once, so a slow crystal stays safe
    assign clrStartup    = inStartupHold;                                        // RQ4
    assign clrInstr      = watchdogClearInstr;                                   // RQ6
    assign clrOscFail    = oscFail;                                              // RQ9
    // The counter wraps to zero on the time-out it reports
    assign clrWrap       = atTerm;
    assign clearNow      = clrDisabled || clrSleepEntry || clrSleepHeld || clrWake
                           || clrStartup || clrInstr || clrOscFail || clrWrap
                           || (dividerUnused && 1'b0);

    // ----------------------------------------
    // Next values
    // ----------------------------------------
    wire logic [CNT_W-1:0] next_count;
    wire logic             next_active;
    wire wdcc_flags_s      next_flags;

    // Clear sources win over the count
    assign next_count  = clearNow  ? '0
                       : countTick ? watchdogCounter + 1'b1
                       : watchdogCounter;
    assign next_active = enabledNow && !clearNow;
    // The sleep time-out wins over a flag clear in the same cycle
    assign next_flags  = wakeByTimeout ? FLAGS_WAKE                              // RQ8
                       : flagClear     ? FLAGS_IDLE
                       : flags;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= WDCC_ST_AWAKE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            watchdogCounter <= '0;
        end else begin
            watchdogCounter <= next_count;                                       // RQ6 RQ9
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            watchdogActive <= 1'b0;
        end else begin
            watchdogActive <= next_active;
        end
    end

    // Time-out pulses stand for one cycle
    always_ff @(posedge core_clk) begin
        if (reset) begin
            timeoutReset <= 1'b0;
            timeoutWake  <= 1'b0;
        end else begin
            timeoutReset <= awakeTimeout;
            timeoutWake  <= wakeByTimeout;                                       // RQ8
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            flags <= FLAGS_IDLE;
        end else begin
            flags <= next_flags;                                                 // RQ8
        end
    end

endmodule
`default_nettype wire

// [design/wdcc_pkg.sv]
// Purpose: Shared constants and types for the watchdog clear control
// Assumes: Mode field is the two-bit configured watchdog mode
// Notes:   System clock source codes are local to this block
`default_nettype none
package wdcc_pkg;

    // ----------------------------------------
    // Mode field decode
    // ----------------------------------------
    typedef enum logic [1:0] {
        WDCC_MODE_OFF    = 2'b00,
        WDCC_MODE_SW     = 2'b01,
        WDCC_MODE_AWAKE  = 2'b10,
        WDCC_MODE_ALWAYS = 2'b11
    } wdcc_mode_e;

    // ----------------------------------------
    // System clock source in use
    // ----------------------------------------
    typedef enum logic [2:0] {
        WDCC_CLK_INTERNAL   = 3'b000,
        WDCC_CLK_SECONDARY  = 3'b001,
        WDCC_CLK_EXT_RC     = 3'b010,
        WDCC_CLK_EXT_INPUT  = 3'b011,
        WDCC_CLK_XTAL_LP    = 3'b100,
        WDCC_CLK_XTAL_MED   = 3'b101,
        WDCC_CLK_XTAL_HS    = 3'b110
    } wdcc_clk_e;

    // Wake-phase states
    typedef enum logic [1:0] {
        WDCC_ST_AWAKE   = 2'b00,
        WDCC_ST_SLEEP   = 2'b01,
        WDCC_ST_OSTWAIT = 2'b10
    } wdcc_state_e;

    // Control inputs that travel together
    typedef struct packed {
        wdcc_mode_e watchdogModeCfg;
        logic       softwareWatchdogEnable;
        wdcc_clk_e  sysClkSel;
    } wdcc_cfg_s;

    // Status flag pair driven on a sleep-time time-out
    typedef struct packed {
        logic timeoutFlag;
        logic powerdownFlag;
    } wdcc_flags_s;

    localparam int unsigned WDCC_CNT_W_DEF = 18;
    localparam logic [17:0] WDCC_TERM_DEF  = 18'h0_FFFF;
    localparam logic        WDCC_FLAG_RST  = 1'b1;

endpackage
`default_nettype wire

// [verif/tb_watchdog_clear_control.sv]
// Purpose: Directed bench for the watchdog clear control
// Assumes: Terminal count shortened to 8 to keep time-outs quick
// Notes:   Inputs move 1 ns after each rising edge
`timescale 1ns/1ps
`default_nettype none
module tb_watchdog_clear_control;
    import wdcc_pkg::*;
    logic core_clk, reset, lfTick, sEn, sEx, oscFail, clr, done, fClr, act, tR, tW;
    logic [3:0] divSel, cnt;
    wdcc_cfg_s cfg;
    wdcc_flags_s flags;
    int failures, n_tests;
    wdcc_core #(.CNT_W(4), .TERM(4'h8)) DUT (.core_clk(core_clk), .reset(reset),
        .lfTick(lfTick), .cfg(cfg), .sleepEnter(sEn), .sleepExit(sEx), .oscFail(oscFail),
        .watchdogClearInstr(clr), .oscStartupTimerDone(done), .internalOscDividerSel(divSel),
        .flagClear(fClr), .watchdogCounter(cnt), .watchdogActive(act), .timeoutReset(tR),
        .timeoutWake(tW), .flags(flags));
    initial begin
        core_clk = 0;
        forever #5 core_clk = ~core_clk;
    end
    task step; @(posedge core_clk); #1; endtask
    task chk(input string nm, input logic [3:0] e, input logic [3:0] g);
        n_tests++;
        if (g !== e) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
        $display("test %s done", nm);
    endtask
    task tick(input int n); lfTick = 1; repeat (n) step; lfTick = 0; step; endtask
    task final_report;
        $display("checks %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Ticks until the chosen time-out pulse shows; a missing pulse ends the run
    task waitTo(input logic wake);
        lfTick = 1;
        for (int i = 0; i < 20 && (wake ? tW : tR) !== 1'b1; i++) step;
        if ((wake ? tW : tR) !== 1'b1) begin failures++; final_report; end
    endtask
    initial begin
        {reset, lfTick, sEn, sEx, oscFail, clr, done, fClr, divSel} = 12'h800;
        failures = 0; n_tests = 0;
        cfg = '{WDCC_MODE_ALWAYS, 1'b0, WDCC_CLK_INTERNAL};
        repeat (8) step;
        reset = 0;
        chk("reset flags", 4'h3, {2'b00, flags});
        tick(3); divSel = 4'h5; tick(2); chk("divider", 4'h5, cnt);
        clr = 1; tick(1); clr = 0; chk("clear", 4'h0, cnt);
        tick(2); oscFail = 1; step; oscFail = 0; step; chk("oscfail", 4'h0, cnt);
        for (int m = 0; m < 8; m++) begin
            cfg.watchdogModeCfg = wdcc_mode_e'(m[2:1]);
            cfg.softwareWatchdogEnable = m[0];
            clr = 1; step; clr = 0; tick(3);
            chk("mode", (m < 3) ? 4'h0 : 4'h3, cnt);
            chk("mode active", {3'b000, m > 2}, {3'b000, act});
        end
        waitTo(1'b0); lfTick = 0; chk("awake timeout", 4'h0, cnt);
        cfg.watchdogModeCfg = WDCC_MODE_AWAKE;
        sEn = 1; step; sEn = 0; tick(4); chk("sleep hold", 4'h0, cnt);
        cfg.watchdogModeCfg = WDCC_MODE_ALWAYS;
        tick(2); chk("sleep count", 4'h2, cnt);
        sEx = 1; step; sEx = 0; tick(2); chk("wake count", 4'h2, cnt);
        cfg = '{WDCC_MODE_ALWAYS, 1'b0, WDCC_CLK_XTAL_HS};
        sEn = 1; step; sEn = 0; waitTo(1'b1);
        chk("sleep timeout", 4'h0, {2'b00, flags});
        chk("no reset", 4'h0, {3'b000, tR});
        repeat (3) step; lfTick = 0; step; chk("startup hold", 4'h0, cnt);
        done = 1; step; done = 0; tick(3); chk("after startup", 4'h3, cnt);
        fClr = 1; step; fClr = 0; step; chk("flag clear", 4'h3, {2'b00, flags});
        for (int c = 0; c < 7; c++) begin
            cfg = '{WDCC_MODE_AWAKE, 1'b0, wdcc_clk_e'(c[2:0])};
            sEn = 1; step; sEn = 0; sEx = 1; step; sEx = 0; tick(3);
            chk("wake clock", (c > 3) ? 4'h0 : 4'h3, cnt);
            chk("wake active", {3'b000, c < 4}, {3'b000, act});
            done = 1; step; done = 0;
        end
        tick(2); reset = 1; step; reset = 0; chk("reset clear", 4'h0, cnt);
        tick(1); chk("after reset", 4'h1, cnt);
        final_report;
    end
endmodule
`default_nettype wire

// [verif/wdcc_props.sv]
// Purpose: Port-level checks for the watchdog clear control
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound onto every wdcc_core instance
`timescale 1ns/1ps
`default_nettype none
module wdcc_props
    import wdcc_pkg::*;
#(
    parameter int unsigned      CNT_W = WDCC_CNT_W_DEF,
    parameter logic [CNT_W-1:0] TERM  = WDCC_TERM_DEF[CNT_W-1:0]
) (
    input wire logic             core_clk,
    input wire logic             reset,
    input wire logic             lfTick,
    input wire wdcc_cfg_s        cfg,
    input wire logic             sleepEnter,
    input wire logic             oscFail,
    input wire logic             watchdogClearInstr,
    input wire logic [CNT_W-1:0] watchdogCounter,
    input wire logic             timeoutReset,
    input wire logic             timeoutWake,
    input wire wdcc_flags_s      flags
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    wire logic wdOff = cfg.watchdogModeCfg == WDCC_MODE_OFF
        || (cfg.watchdogModeCfg == WDCC_MODE_SW && !cfg.softwareWatchdogEnable);
    AST_OFF: assert property (wdOff |=> watchdogCounter == '0)
        else $error("counter not held while disabled");
    AST_SLP: assert property (sleepEnter && cfg.watchdogModeCfg == WDCC_MODE_AWAKE
        |=> watchdogCounter == '0) else $error("sleep entry did not clear");
    AST_CLR: assert property (watchdogClearInstr |=> watchdogCounter == '0)
        else $error("clear instruction ignored");
    AST_OSC: assert property (oscFail |=> watchdogCounter == '0)
        else $error("oscillator fail did not clear");
    AST_HOLD: assert property (!$past(lfTick) |-> $stable(watchdogCounter)
        || watchdogCounter == '0) else $error("counter moved without tick");
    AST_TOR: assert property (timeoutReset |-> $past(watchdogCounter) == TERM
        && watchdogCounter == '0) else $error("awake time-out at wrong count");
    AST_TOW: assert property (timeoutWake |-> flags == 2'b00 && !timeoutReset)
        else $error("sleep time-out flags wrong");
    AST_WCNT: assert property (timeoutWake |-> $past(lfTick)
        && $past(watchdogCounter) == TERM) else $error("sleep time-out at wrong count");
endmodule
bind wdcc_core wdcc_props #(.CNT_W(CNT_W), .TERM(TERM)) uProps (.core_clk(core_clk),
    .reset(reset), .lfTick(lfTick), .cfg(cfg), .sleepEnter(sleepEnter), .oscFail(oscFail),
    .watchdogClearInstr(watchdogClearInstr), .watchdogCounter(watchdogCounter),
    .timeoutReset(timeoutReset), .timeoutWake(timeoutWake), .flags(flags));
`default_nettype wire
